// *** src/iscbs_params.svh ***
// Constants of the two-wire stop/collision, rate counter and status block.
// Assumes byte-wide registers, one per aligned 32-bit word.
`ifndef ISCBS_PARAMS_SVH
`define ISCBS_PARAMS_SVH
// Register byte offsets
`define ISCBS_OFF_RELOAD 8'h00
`define ISCBS_OFF_BUF    8'h04
`define ISCBS_OFF_CTL1   8'h08
`define ISCBS_OFF_CTL2   8'h0C
`define ISCBS_OFF_CTL3   8'h10
`define ISCBS_OFF_MASK   8'h14
`define ISCBS_OFF_STAT   8'h18
`define ISCBS_OFF_FLAGS  8'h1C
// Reset values
`define ISCBS_RST_REG    8'h00
// Control one fields
`define ISCBS_C1_WCOL    7
`define ISCBS_C1_OV      6
`define ISCBS_C1_EN      5
// Control two fields
`define ISCBS_C2_ACK_REQUEST   4
`define ISCBS_C2_RECEIVE_REQUEST    3
`define ISCBS_C2_PEN     2
`define ISCBS_C2_RESTART_REQUEST    1
`define ISCBS_C2_SEN     0
// Status fields
`define ISCBS_ST_SMP     7
`define ISCBS_ST_CKE     6
`define ISCBS_ST_DA      5
`define ISCBS_ST_P       4
`define ISCBS_ST_S       3
`define ISCBS_ST_RW      2
`define ISCBS_ST_UA      1
`define ISCBS_ST_BF      0
// Event flag fields
`define ISCBS_FL_EVT     0
`define ISCBS_FL_COL     1
// Mode codes of control one bits 3..0
`define ISCBS_M_I2C_MST  4'h8
`define ISCBS_M_I2C_FW   4'hB
`define ISCBS_M_SPI_RATE 4'hA
// System clocks per rate counter step (Fosc/4 rule: two clocks per step)
`define ISCBS_RATE_PRESCALE 2
`endif

// *** src/iscbs_pkg.sv ***
// Types of the two-wire stop/collision, rate counter and status block.
// Assumes iscbs_params.svh holds all numeric constants.
package iscbs_pkg;
   // Stop sequence states
   typedef enum logic [2:0] {
      SP_IDLE, SP_SDA_LOW, SP_SCL_REL, SP_HOLD, SP_SDA_REL, SP_TAIL
   } iscbs_stop_t;
   // Events from the byte sequencer, same clock, one-cycle pulses
   typedef struct packed {
      logic       rx_done;
      logic       tx_done;
      logic       op_done;
      logic       is_data;
      logic       addr_match;
      logic       rw_bit;
      logic       nack;
      logic       ua_set;
      logic       req_done;
      logic [7:0] rx_byte;
   } iscbs_evt_t;
   // Pad and shifter configuration
   typedef struct packed {
      logic slew_disable;
      logic smbus_levels;
      logic spi_sample_end;
      logic spi_tx_act_idle;
   } iscbs_cfg_t;
endpackage : iscbs_pkg

// *** src/iscbs_top.sv ***
// Stop condition collision checks, rate counter and port status registers.
// Assumes a byte sequencer on the same clock supplies events and a
// Wishbone classic master reaches the registers.
// Function
// RULE_01: In stop, after SDA release and counter expiry, SDA low means collision.
// RULE_02: In stop, SCL sampled low before SDA goes high means collision.
// RULE_03: Stop: drive SDA low, release SCL, on SCL high load and count.
// RULE_04: Counter reloads from reload register; buffer write starts counting.
// RULE_05: When operation completes, counter stops and clock pin holds level.
// RULE_06: Counter reloads twice per generated clock period.
// RULE_07: Generated clock is Fosc divided by four times reload plus one.
// RULE_08: Software avoids reload values zero, one and two in two-wire mode.
// RULE_09: Two-wire: status bit 7 set disables slew control.
// RULE_10: SPI master: status bit 7 picks end or middle sampling.
// RULE_11: SPI: status bit 6 set changes data on active-to-idle edge.
// RULE_12: Two-wire: status bit 6 set selects SMBus input thresholds.
// RULE_13: Status bit 5 shows last byte was data, else address.
// RULE_14: Status bit 4 shows stop seen last; zero on reset or disable.
// RULE_15: Status bit 3 shows start seen last; zero on reset or disable.
// RULE_16: Slave: status bit 2 holds read/write until start, stop, nack.
// RULE_17: Master: status bit 2 shows transmit in progress; idle output.
// RULE_18: Ten-bit slave: status bit 1 asks for address update.
// RULE_19: Receive: status bit 0 sets when byte complete, buffer full.
// RULE_20: Two-wire transmit: status bit 0 high while data byte shifts.
// RULE_21: Collision sets collision flag and returns port to idle.
// RULE_22: A counter period after stop, clear stop request, set event flag.
// RULE_23: Pins pass two synchroniser flops before any check.
`timescale 1ns/1ns
`default_nettype none
`include "iscbs_params.svh"
module iscbs_top #(
   parameter int RATE_PRESCALE = `ISCBS_RATE_PRESCALE
) (
   // Clock and reset
   input  wire logic              CLOCK,
   input  wire logic              RST_N,
   // Wishbone classic slave
   input  wire logic              WB_CYC_I,
   input  wire logic              WB_STB_I,
   input  wire logic              WB_WE_I,
   input  wire logic [7:0]        WB_ADR_I,
   input  wire logic [3:0]        WB_SEL_I,
   input  wire logic [31:0]       WB_DAT_I,
   output logic [31:0]            WB_DAT_O,
   output logic                   WB_ACK_O,
   // Two-wire pins, enable low while pulling low
   input  wire logic              SCL_IN,
   output logic                   SCL_OUT,
   output logic                   SCL_OE_N,
   input  wire logic              SDA_IN,
   output logic                   SDA_OUT,
   output logic                   SDA_OE_N,
   // Byte sequencer side
   input  wire iscbs_pkg::iscbs_evt_t EVT,
   output logic                   TX_START,
   output logic [7:0]             TX_BYTE,
   output logic                   RATE_CLK,
   output logic                   PORT_IDLE,
   output logic                   COLLISION,
   output logic                   SERIAL_EVENT,
   output iscbs_pkg::iscbs_cfg_t  CFG
);
   import iscbs_pkg::*;

   // Elaboration check: the prescaler is an 8-bit counter
   if (RATE_PRESCALE < 1 || RATE_PRESCALE > 255) begin : g_bad_prescale
      $error("RATE_PRESCALE out of range");
   end

   logic [7:0]  reload, buffer, ctl1, ctl2, ctl3, mask, stat;
   logic        evt_flag, col_flag;
   logic [1:0]  scl_sy, sda_sy;
   logic        sda_prev;
   logic [7:0]  cnt, pre;
   logic        gen_run, gen_clk;
   iscbs_stop_t state;

   // Bus decode
   wire acc     = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
   wire wr      = acc & WB_WE_I & WB_SEL_I[0];
   wire rd      = acc & ~WB_WE_I;
   wire [7:0] d = WB_DAT_I[7:0];
   wire en      = ctl1[`ISCBS_C1_EN];
   wire [3:0] mode = ctl1[3:0];

   function automatic logic is_i2c(input logic [3:0] m);
      is_i2c = (m == 4'h6) || (m == 4'h7) || (m == `ISCBS_M_I2C_MST) ||
               (m == `ISCBS_M_I2C_FW) || (m == 4'hE) || (m == 4'hF);
   endfunction : is_i2c

   wire i2c     = is_i2c(mode);
   wire i2c_mst = (mode == `ISCBS_M_I2C_MST);
   wire spi_mst = (mode[3:2] == 2'b00) || (mode == `ISCBS_M_SPI_RATE);
   wire ten_bit = (mode == 4'h7) || (mode == 4'hF);
   wire slave   = i2c & ~i2c_mst & (mode != `ISCBS_M_I2C_FW);

   // Synchronised pin levels; first stage feeds only the second
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         scl_sy   <= 2'h3;
         sda_sy   <= 2'h3;
         sda_prev <= 1'b1;
      end else begin
         scl_sy   <= {scl_sy[0], SCL_IN};   // RULE_23
         sda_sy   <= {sda_sy[0], SDA_IN};   // RULE_23
         sda_prev <= sda_sy[1];
      end
   end
   wire scl_s     = scl_sy[1];
   wire sda_s     = sda_sy[1];
   wire start_det = scl_s & sda_prev & ~sda_s;
   wire stop_det  = scl_s & ~sda_prev & sda_s;

   // Buffer write is refused while a stop sequence runs
   wire buf_wr    = wr && (WB_ADR_I == `ISCBS_OFF_BUF);
   wire buf_ok    = buf_wr && (state == SP_IDLE) && en;
   wire buf_rd    = rd && (WB_ADR_I == `ISCBS_OFF_BUF);

   // Stop sequence timing uses the rate counter
   wire fsm_run   = (state == SP_HOLD) || (state == SP_SDA_REL) ||
                    (state == SP_TAIL);
   wire run       = gen_run | fsm_run;
   wire tick      = (pre == 8'(RATE_PRESCALE - 1));
   wire expire    = run & tick & (cnt == 8'h00);
   logic fsm_load, collide, stop_done;

   // Stop sequence state machine
   always_comb begin
      fsm_load  = 1'b0;
      collide   = 1'b0;
      stop_done = 1'b0;
      case (state)
         SP_SCL_REL: fsm_load = scl_s;                      // RULE_03
         SP_HOLD: begin
            collide  = ~scl_s;                              // RULE_02
            fsm_load = scl_s & expire;
         end
         SP_SDA_REL: begin
            collide  = (~scl_s & ~sda_s) | (expire & ~sda_s); // RULE_01 RULE_02
            fsm_load = expire & sda_s;
         end
         SP_TAIL: stop_done = expire;                       // RULE_22
         default: fsm_load = 1'b0;
      endcase
   end

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         state <= SP_IDLE;
      end else if (!en || collide) begin
         state <= SP_IDLE;                                  // RULE_21
      end else begin
         case (state)
            SP_IDLE:
               if (ctl2[`ISCBS_C2_PEN] && i2c_mst) begin
                  state <= SP_SDA_LOW;                      // RULE_03
               end
            SP_SDA_LOW: if (!sda_s && !scl_s) state <= SP_SCL_REL; // RULE_03
            SP_SCL_REL: if (scl_s) state <= SP_HOLD;
            SP_HOLD:    if (expire) state <= SP_SDA_REL;
            SP_SDA_REL: if (expire) state <= SP_TAIL;
            SP_TAIL:    if (expire) state <= SP_IDLE;
            default:    state <= SP_IDLE;
         endcase
      end
   end

   // Pin drivers: SDA low from request until release, SCL low until sampled
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         SCL_OUT  <= 1'b0;
         SDA_OUT  <= 1'b0;
         SCL_OE_N <= 1'b1;
         SDA_OE_N <= 1'b1;
      end else begin
         SCL_OUT  <= 1'b0;
         SDA_OUT  <= 1'b0;
         // Hold SCL until both lines are seen low, so a stale synchronised
         // high cannot pass for the released clock in the next state
         SCL_OE_N <= !(en && !collide && (state == SP_IDLE ?
                       ctl2[`ISCBS_C2_PEN] && i2c_mst : state == SP_SDA_LOW &&
                       (sda_s || scl_s)));                  // RULE_03
         SDA_OE_N <= !(en && !collide && (state == SP_IDLE ?
                       ctl2[`ISCBS_C2_PEN] && i2c_mst :
                       state inside {SP_SDA_LOW, SP_SCL_REL} ||
                       (state == SP_HOLD && !expire)));
      end
   end

   // Rate counter: reload on each expiry gives two reloads per period
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         cnt <= 8'h00;
         pre <= 8'h00;
      end else if (fsm_load || buf_ok) begin
         cnt <= reload;                                     // RULE_04
         pre <= 8'h00;
      end else if (run) begin
         pre <= tick ? 8'h00 : pre + 8'h01;
         if (tick) begin
            cnt <= (cnt == 8'h00) ? reload : cnt - 8'h01;   // RULE_06 RULE_07
         end
      end
   end

   // Generated clock runs from buffer write until the operation ends
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         gen_run <= 1'b0;
         gen_clk <= 1'b0;
      end else begin
         if (!en || collide || EVT.op_done) begin
            gen_run <= 1'b0;                                // RULE_05
         end else if (buf_ok) begin
            gen_run <= 1'b1;                                // RULE_04
         end
         if (expire && gen_run) begin
            gen_clk <= ~gen_clk;                            // RULE_07
         end
      end
   end

   // Software registers; hardware sets win over software clears
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         reload <= `ISCBS_RST_REG;
         ctl1   <= `ISCBS_RST_REG;
         ctl3   <= `ISCBS_RST_REG;
         mask   <= `ISCBS_RST_REG;
      end else begin
         if (wr && WB_ADR_I == `ISCBS_OFF_RELOAD) reload <= d;
         if (wr && WB_ADR_I == `ISCBS_OFF_CTL3) ctl3 <= {1'b0, d[6:0]};
         if (wr && WB_ADR_I == `ISCBS_OFF_MASK) mask <= d;
         if (wr && WB_ADR_I == `ISCBS_OFF_CTL1) begin
            ctl1[5:0] <= d[5:0];
            ctl1[7:6] <= ctl1[7:6] & d[7:6];
         end
         if (buf_wr && !buf_ok) ctl1[`ISCBS_C1_WCOL] <= 1'b1;
         if (EVT.rx_done && en && stat[`ISCBS_ST_BF]) begin
            ctl1[`ISCBS_C1_OV] <= 1'b1;
         end
      end
   end

   // Request bits: software sets, hardware clears on completion or collision
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         ctl2 <= `ISCBS_RST_REG;
      end else if (!en || collide) begin
         ctl2 <= ctl2 & 8'hE0;                              // RULE_21
      end else begin
         if (wr && WB_ADR_I == `ISCBS_OFF_CTL2) ctl2 <= d;
         if (stop_done) ctl2[`ISCBS_C2_PEN] <= 1'b0;       // RULE_22
         if (EVT.req_done) begin
            ctl2[`ISCBS_C2_SEN]   <= 1'b0;
            ctl2[`ISCBS_C2_RESTART_REQUEST]  <= 1'b0;
            ctl2[`ISCBS_C2_RECEIVE_REQUEST]  <= 1'b0;
            ctl2[`ISCBS_C2_ACK_REQUEST] <= 1'b0;
         end
      end
   end

   // Transfer buffer: receive loads it, accepted writes replace it
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         buffer   <= `ISCBS_RST_REG;
         TX_START <= 1'b0;
      end else begin
         TX_START <= buf_ok;
         if (buf_ok) begin
            buffer <= d;
         end else if (EVT.rx_done && en) begin
            buffer <= EVT.rx_byte;
         end
      end
   end

   // Status bits 7 and 6 are software settings
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         stat[7:6] <= 2'h0;
      end else if (wr && WB_ADR_I == `ISCBS_OFF_STAT) begin
         stat[7:6] <= d[7:6];
      end
   end

   // Bus condition and byte type tracking
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         stat[5:3] <= 3'h0;
      end else if (!en) begin
         stat[`ISCBS_ST_P] <= 1'b0;                         // RULE_14
         stat[`ISCBS_ST_S] <= 1'b0;                         // RULE_15
      end else begin
         if (EVT.rx_done || EVT.tx_done) begin
            stat[`ISCBS_ST_DA] <= EVT.is_data;              // RULE_13
         end
         if (stop_det) begin
            stat[`ISCBS_ST_P] <= 1'b1;                      // RULE_14
            stat[`ISCBS_ST_S] <= 1'b0;
         end else if (start_det) begin
            stat[`ISCBS_ST_S] <= 1'b1;                      // RULE_15
            stat[`ISCBS_ST_P] <= 1'b0;
         end
      end
   end

   // Direction or transmit-active bit
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         stat[`ISCBS_ST_RW] <= 1'b0;
      end else if (!en || collide) begin
         stat[`ISCBS_ST_RW] <= 1'b0;
      end else if (slave) begin
         if (EVT.addr_match) begin
            stat[`ISCBS_ST_RW] <= EVT.rw_bit;               // RULE_16
         end else if (start_det || stop_det || EVT.nack) begin
            stat[`ISCBS_ST_RW] <= 1'b0;                     // RULE_16
         end
      end else if (buf_ok) begin
         stat[`ISCBS_ST_RW] <= 1'b1;                        // RULE_17
      end else if (EVT.tx_done) begin
         stat[`ISCBS_ST_RW] <= 1'b0;
      end
   end

   // Address update request, cleared by writing the reload register
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         stat[`ISCBS_ST_UA] <= 1'b0;
      end else if (EVT.ua_set && ten_bit && en) begin
         stat[`ISCBS_ST_UA] <= 1'b1;                        // RULE_18
      end else if (!en || (wr && WB_ADR_I == `ISCBS_OFF_RELOAD)) begin
         stat[`ISCBS_ST_UA] <= 1'b0;
      end
   end

   // Buffer full: receive or two-wire transmit load sets, read or byte end clears
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         stat[`ISCBS_ST_BF] <= 1'b0;
      end else if (EVT.rx_done && en) begin
         stat[`ISCBS_ST_BF] <= 1'b1;                        // RULE_19
      end else if (buf_ok && i2c) begin
         stat[`ISCBS_ST_BF] <= 1'b1;                        // RULE_20
      end else if (!en || collide || buf_rd || EVT.tx_done) begin
         stat[`ISCBS_ST_BF] <= 1'b0;                        // RULE_20
      end
   end

   // Event flags, write one to clear; a same-cycle set wins
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         evt_flag <= 1'b0;
         col_flag <= 1'b0;
      end else begin
         if (stop_done) begin
            evt_flag <= 1'b1;                               // RULE_22
         end else if (wr && WB_ADR_I == `ISCBS_OFF_FLAGS &&
                      d[`ISCBS_FL_EVT]) begin
            evt_flag <= 1'b0;
         end
         if (collide) begin
            col_flag <= 1'b1;                               // RULE_21
         end else if (wr && WB_ADR_I == `ISCBS_OFF_FLAGS &&
                      d[`ISCBS_FL_COL]) begin
            col_flag <= 1'b0;
         end
      end
   end

   // Registered outputs towards pads, shifter and sequencer
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         CFG          <= '0;
         RATE_CLK     <= 1'b0;
         PORT_IDLE    <= 1'b1;
         COLLISION    <= 1'b0;
         SERIAL_EVENT <= 1'b0;
         TX_BYTE      <= 8'h00;
      end else begin
         CFG.slew_disable    <= i2c & stat[`ISCBS_ST_SMP];     // RULE_09
         CFG.smbus_levels    <= i2c & stat[`ISCBS_ST_CKE];     // RULE_12
         CFG.spi_sample_end  <= spi_mst & stat[`ISCBS_ST_SMP]; // RULE_10
         CFG.spi_tx_act_idle <= ~i2c & stat[`ISCBS_ST_CKE];    // RULE_11
         RATE_CLK     <= gen_clk;                              // RULE_05
         PORT_IDLE    <= ~(stat[`ISCBS_ST_RW] | (|ctl2[4:0])); // RULE_17
         COLLISION    <= col_flag;
         SERIAL_EVENT <= evt_flag;
         TX_BYTE      <= buffer;
      end
   end

   // Bus answer one cycle after request; unmapped reads return zero
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         WB_ACK_O <= 1'b0;
         WB_DAT_O <= 32'h0000_0000;
      end else begin
         WB_ACK_O <= acc;
         if (rd) begin
            if (WB_ADR_I == `ISCBS_OFF_RELOAD) WB_DAT_O <= {24'h0, reload};
            else if (WB_ADR_I == `ISCBS_OFF_BUF) WB_DAT_O <= {24'h0, buffer};
            else if (WB_ADR_I == `ISCBS_OFF_CTL1) WB_DAT_O <= {24'h0, ctl1};
            else if (WB_ADR_I == `ISCBS_OFF_CTL2) WB_DAT_O <= {24'h0, ctl2};
            else if (WB_ADR_I == `ISCBS_OFF_CTL3) WB_DAT_O <= {24'h0, ctl3};
            else if (WB_ADR_I == `ISCBS_OFF_MASK) WB_DAT_O <= {24'h0, mask};
            else if (WB_ADR_I == `ISCBS_OFF_STAT) WB_DAT_O <= {24'h0, stat};
            else if (WB_ADR_I == `ISCBS_OFF_FLAGS)
               WB_DAT_O <= {30'h0, col_flag, evt_flag};
            else WB_DAT_O <= 32'h0000_0000;
         end
      end
   end

   // Checks
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RST_N);

   // Half period measured between expiries with no reload in between
   logic [15:0] hc;
   logic        seen;
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         hc   <= 16'h0000;
         seen <= 1'b0;
      end else begin
         hc   <= (fsm_load || buf_ok || expire) ? 16'h0000 : hc + 16'h0001;
         seen <= (fsm_load || buf_ok || wr) ? 1'b0 : (seen | expire);
      end
   end

   a_stop_sda_low: assert property ((state == SP_SDA_REL) && expire && !sda_s
      |=> col_flag && state == SP_IDLE) else $error("sda collision missed"); // RULE_01
   a_stop_scl_low: assert property ((state == SP_HOLD) && !scl_s && en
      |=> col_flag && SCL_OE_N && SDA_OE_N) else $error("scl collision missed"); // RULE_02
   a_stop_load_cnt: assert property ((state == SP_SCL_REL) && scl_s && en && !wr
      |=> state == SP_HOLD && cnt == $past(reload)) else $error("stop load wrong"); // RULE_03
   a_buf_starts: assert property (buf_ok && !EVT.op_done
      |=> gen_run && cnt == $past(reload)) else $error("buffer write no start"); // RULE_04
   a_clk_holds: assert property (!gen_run |=> ##1 $stable(RATE_CLK))
      else $error("clock moved when stopped"); // RULE_05
   a_half_period: assert property (expire && seen
      |-> hc == 16'((32'(reload) + 1) * RATE_PRESCALE - 1)) else $error("rate wrong"); // RULE_06 RULE_07
   a_stop_flag: assert property (en && stop_det
      |=> stat[`ISCBS_ST_P] && !stat[`ISCBS_ST_S]) else $error("stop not flagged"); // RULE_14
   a_disable_clr: assert property (!en
      |=> !stat[`ISCBS_ST_P] && !stat[`ISCBS_ST_S]) else $error("disable kept flags"); // RULE_15
   a_tail_event: assert property ((state == SP_TAIL) && expire && en
      |=> !ctl2[`ISCBS_C2_PEN] && evt_flag ##1 SERIAL_EVENT) else $error("stop end wrong"); // RULE_22
   a_rx_full: assert property (EVT.rx_done && en
      |=> stat[`ISCBS_ST_BF] ##1 !PORT_IDLE || stat[`ISCBS_ST_BF]) else $error("bf not set"); // RULE_19

   c_stop_done: cover property ((state == SP_TAIL) && expire);
   c_collision: cover property (collide);
   c_buf_refused: cover property (buf_wr && !buf_ok);
endmodule : iscbs_top
`default_nettype wire

// *** tb/iscbs_bus_model.sv ***
// Open-drain two-wire bus with pull-ups and a second master that can pull low.
// Assumes an enable that is low means the block is pulling the line low.
`timescale 1ns/1ns
`default_nettype none
module iscbs_bus_model (
   // Block side
   input  wire logic scl_oe_n,
   input  wire logic sda_oe_n,
   // Other master, high pulls the line low
   input  wire logic hold_scl,
   input  wire logic hold_sda,
   // Wire levels
   output logic      scl,
   output logic      sda
);
   // Wired-AND with pull-up, so a released line floats high unless held
   assign scl = scl_oe_n & ~hold_scl;
   assign sda = sda_oe_n & ~hold_sda;
endmodule : iscbs_bus_model
`default_nettype wire

// *** tb/testbench.sv ***
// Bench for the stop collision checks, rate counter and status registers.
// Assumes the bus model stands in for the other parties on the wires.
`timescale 1ns/1ns
`default_nettype none
`include "iscbs_params.svh"
module testbench;
   import iscbs_pkg::*;
   logic        clock = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, l;
   logic        hold_scl = 0, hold_sda = 0, scl, sda, ack, so, sdo;
   logic        scl_oe_n, sda_oe_n, tx_start, rate_clk, port_idle, coll, sev;
   logic [7:0]  adr = 8'h00, tx_byte, reload, b, r;
   logic [31:0] dat = 32'h0, rdat;
   iscbs_evt_t  evt = '0;
   iscbs_cfg_t  cfg;
   int          miscompares = 0, checks_done = 0, n;
   logic [7:0]  exp_q[$];
   iscbs_top u_iscbs_top (.CLOCK(clock), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
      .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(dat), .WB_DAT_O(rdat),
      .WB_ACK_O(ack), .SCL_IN(scl), .SCL_OUT(so), .SCL_OE_N(scl_oe_n), .SDA_IN(sda),
      .SDA_OUT(sdo), .SDA_OE_N(sda_oe_n), .EVT(evt), .TX_START(tx_start), .TX_BYTE(tx_byte),
      .RATE_CLK(rate_clk), .PORT_IDLE(port_idle), .COLLISION(coll), .SERIAL_EVENT(sev),
      .CFG(cfg));
   iscbs_bus_model u_iscbs_bus_model (.scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n),
      .hold_scl(hold_scl), .hold_sda(hold_sda), .scl(scl), .sda(sda));
   // Free-running system clock
   initial forever #20 clock = ~clock;
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         miscompares++;
         $display("ERROR %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   // Classic single cycle; held until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= {24'h0, d};
      do @(posedge clock); while (ack !== 1'b1);
      cyc <= 0; stb <= 0; we <= 0;
   endtask : wb
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      wb(0, a, 8'h00);
   endtask : rd
   // Bounded wait for the stop to finish either way
   task automatic wait_ev;
      n = 0;
      while (!(sev | coll) && n < 3000) begin @(posedge clock); n++; end
      if (n >= 3000) begin
         miscompares++;
         $display("ERROR %0t: stop sequence never ended", $time);
      end
   endtask : wait_ev
   // Read data is taken at the ack edge and matched to the oldest note
   always @(posedge clock) if (ack === 1'b1 && we === 1'b0) begin
      if (exp_q.size() == 0) chk(rdat, 32'hFFFF_FFFF);
      else chk(rdat, {24'h0, exp_q.pop_front()});
   end
   task automatic end_of_test;
      $display("checks %0d, mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : end_of_test
   // Watchdog sized well beyond the expected run
   initial begin #(40 * 30000); miscompares++; end_of_test; end
   initial begin
      void'($urandom(82));
      repeat (10) @(posedge clock);
      rst_n <= 1;
      rd(`ISCBS_OFF_STAT, 8'h00);
      rd(`ISCBS_OFF_FLAGS, 8'h00);
      rd(8'h20, 8'h00);
      $display("test reset values done");
      reload = 8'h03 + 8'($urandom % 8);
      b = 8'($urandom);
      wb(1, `ISCBS_OFF_RELOAD, reload);
      wb(1, `ISCBS_OFF_CTL1, 8'h28);
      wb(1, `ISCBS_OFF_STAT, 8'hC0);
      rd(`ISCBS_OFF_STAT, 8'hC0);
      chk(cfg, 4'hC);
      wb(1, `ISCBS_OFF_BUF, b);
      chk(tx_start, 1'b1);
      l = rate_clk; n = 0;
      while (rate_clk === l && n < 500) begin @(posedge clock); n++; end
      l = rate_clk; n = 0;
      while (rate_clk === l && n < 500) begin @(posedge clock); n++; end
      chk(n, (reload + 1) * `ISCBS_RATE_PRESCALE);
      chk(tx_byte, b);
      rd(`ISCBS_OFF_STAT, 8'hC5);
      chk(port_idle, 1'b0);
      // A data byte ends the transmit and stops the counter
      evt.op_done <= 1;
      evt.tx_done <= 1;
      evt.is_data <= 1;
      @(posedge clock);
      evt.op_done <= 0;
      evt.tx_done <= 0;
      repeat (3) @(posedge clock);
      l = rate_clk;
      repeat (60) @(posedge clock);
      chk(rate_clk, l);
      // A received data byte fills the buffer
      r = 8'($urandom);
      evt.rx_byte <= r;
      evt.rx_done <= 1;
      @(posedge clock);
      evt.rx_done <= 0;
      rd(`ISCBS_OFF_STAT, 8'hE1);
      rd(`ISCBS_OFF_BUF, r);
      $display("test rate counter done");
      wb(1, `ISCBS_OFF_CTL2, 8'h04);
      wait_ev;
      rd(`ISCBS_OFF_CTL2, 8'h00);
      rd(`ISCBS_OFF_FLAGS, 8'h01);
      rd(`ISCBS_OFF_STAT, 8'hF0);
      wb(1, `ISCBS_OFF_FLAGS, 8'h03);
      $display("test clean stop done");
      // Another master keeps SDA low through the stop
      hold_sda <= 1;
      wb(1, `ISCBS_OFF_CTL2, 8'h04);
      wait_ev;
      rd(`ISCBS_OFF_FLAGS, 8'h02);
      rd(`ISCBS_OFF_CTL2, 8'h00);
      chk(port_idle, 1'b1);
      chk({so, sdo}, 2'b00);
      hold_sda <= 0;
      wb(1, `ISCBS_OFF_FLAGS, 8'h03);
      $display("test SDA collision done");
      // Another master pulls SCL low after the block released it
      fork
         wb(1, `ISCBS_OFF_CTL2, 8'h04);
         begin @(negedge scl_oe_n); @(posedge scl_oe_n); repeat (6) @(posedge clock);
            hold_scl <= 1; end
      join
      wait_ev;
      rd(`ISCBS_OFF_FLAGS, 8'h02);
      hold_scl <= 0;
      $display("test SCL collision done");
      wb(1, `ISCBS_OFF_CTL1, 8'h08);
      rd(`ISCBS_OFF_STAT, 8'hE0);
      wb(1, `ISCBS_OFF_BUF, 8'h5A);
      chk(tx_start, 1'b0);
      rd(`ISCBS_OFF_CTL1, 8'h88);
      rd(`ISCBS_OFF_BUF, r);
      $display("test disable done");
      // Ten-bit slave: direction after address match, address update request
      wb(1, `ISCBS_OFF_CTL1, 8'h27);
      evt.ua_set <= 1;
      evt.addr_match <= 1;
      evt.rw_bit <= 1;
      @(posedge clock);
      evt.ua_set <= 0;
      evt.addr_match <= 0;
      rd(`ISCBS_OFF_STAT, 8'hE6);
      evt.nack <= 1;
      @(posedge clock);
      evt.nack <= 0;
      wb(1, `ISCBS_OFF_RELOAD, reload);
      rd(`ISCBS_OFF_STAT, 8'hE0);
      $display("test slave status done");
      wb(1, `ISCBS_OFF_CTL1, 8'h2A);
      @(posedge clock);
      chk(cfg, 4'h3);
      $display("test SPI settings done");
      end_of_test;
   end
endmodule : testbench
`default_nettype wire
